// ==== rtl/ctl_line_handler.sv ====
// Console terminal line handler: mode routing, control characters, echo.
// Assumes an APB master, a UART that delivers rx bytes and takes tx bytes.
//
// Overview of operation
// - Program mode forwards, console mode to console
// - Ctrl-P with enable key enters console
// - Ctrl-P when secured forwarded, no echo
// - Halt switch at power-up enters console
// - Console entry halts only boot processor
// - Continue or start command leaves console
// - Errors print question mark, four hex digits, space
// - Secondary errors prefixed with node number
// - Break steps baud upward, wraps, prompts in console mode
// - Ctrl-C aborts, echoes ^C, kills line
// - Console Ctrl-P acts as Ctrl-C, ^P
// - Ctrl-O toggles discard, echo on start
// - Prompt, error, program mode clear discard
// - Ctrl-S suspends output, no echo
// - Ctrl-Q resumes output, no echo
// - Ctrl-R echoes ^R CR LF, reprints line
// - Ctrl-U kills line, echoes ^U prompt
// - Hardcopy delete echoes backslash, then deleted chars after the first, backslash in place of next char
// - Video delete backs up and erases
// - Escape quotes next char, echoes dollar
// - Return hands line to command processor
// - Ctrl-P ends node pass-through session
// - Baud starts at 1200
`timescale 1ns/10ps
module ctl_line_handler
   import ctl_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire ctl_char_t    rx_char,
   input  wire logic         rx_break,
   input  wire logic         key_enable,
   input  wire logic         key_halt,
   output ctl_char_t         os_char,
   output ctl_char_t         tx_char,
   input  wire logic         tx_ready,
   output logic [2:0]        baud_sel,
   output logic              boot_cpu_halt,
   output ctl_start_t        boot_cpu_start,
   output logic              passthru_end
);
   logic              console_ff;
   logic              discard_ff;
   logic              suspend_ff;
   logic              esc_ff;
   logic              hdel_ff;
   logic              strap_done_ff;
   logic [2:0]        baud_ff;
   logic              halt_ff;
   ctl_start_t        start_ff;
   logic              pend_ff;
   ctl_char_t         os_ff;
   ctl_char_t         tx_ff;
   logic [31:0]       prdata_ff;
   logic              pready_ff;
   logic              pslverr_ff;
   logic [7:0]        line_ff [CTL_LINE_MAX];
   logic [CTL_IDX_W-1:0] len_ff;
   logic              line_rdy_ff;
   logic [CTL_IDX_W-1:0] rd_ix_ff;
   // Sequencer of multi-character echo strings
   typedef enum logic [3:0] {
      CTL_S_IDLE, CTL_S_CRLF_CR, CTL_S_CRLF_LF, CTL_S_PROMPT1,
      CTL_S_PROMPT2, CTL_S_PROMPT3, CTL_S_PROMPT4, CTL_S_REPRINT,
      CTL_S_ERASE2, CTL_S_ERASE3, CTL_S_LETTER, CTL_S_CR_ONLY
   } ctl_seq_t;
   ctl_seq_t          seq_ff;
   logic              seq_reprint_ff;
   logic [CTL_IDX_W-1:0] rp_ix_ff;
   // Error report formatter
   logic [15:0]       err_code_ff;
   logic [3:0]        err_node_ff;
   logic [7:0]        letter_ff;
   logic [3:0]        err_pos_ff;
   logic              err_busy_ff;
   ctl_char_t         q_push;
   logic              q_room;
   ctl_char_t         q_head;
   logic              apb_acc;
   logic              apb_wr;
   logic              apb_rd;
   logic              line_busy;
   logic              rx_con;
   logic              ctl_p_in;
   logic [7:0]        ch;
   logic              abort_in;
   logic [31:0]       ctrl_ff;

   assign apb_acc   = psel && penable && !pready_ff;
   assign apb_wr    = apb_acc && pwrite;
   assign apb_rd    = apb_acc && !pwrite;
   assign line_busy = (seq_ff != CTL_S_IDLE) || err_busy_ff;
   assign ch        = rx_char.data;
   assign ctl_p_in  = rx_char.valid && (ch == CTL_CH_CTRL_P);
   assign rx_con    = rx_char.valid && console_ff && q_room && !line_busy;
   assign abort_in  = rx_con && !esc_ff
                      && (ch == CTL_CH_CTRL_C || ch == CTL_CH_CTRL_P);

   ctl_echo_q u_echo (
      .pclk     (pclk),
      .presetn  (presetn),
      .push     (q_push),
      .can_push (q_room),
      .pop_en   (tx_ready && !suspend_ff && !tx_ff.valid),
      .head     (q_head)
   );

   // Mode control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         console_ff    <= 1'b0;
         strap_done_ff <= 1'b0;
         halt_ff       <= 1'b0;
         start_ff      <= '0;
         pend_ff       <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
         start_ff.valid <= 1'b0;
         pend_ff       <= 1'b0;
         if (!strap_done_ff && key_halt) begin
            console_ff <= 1'b1;
            halt_ff    <= 1'b1;
         end
         if (!console_ff && ctl_p_in && key_enable) begin
            console_ff <= 1'b1;
            halt_ff    <= 1'b1;
            pend_ff    <= 1'b1;
         end
         if (apb_wr && paddr == CTL_A_CMD && console_ff) begin
            unique case (ctl_cmd_t'(pwdata[1:0]))
               CTL_CMD_CONTINUE: begin
                  console_ff <= 1'b0;
                  halt_ff    <= 1'b0;
               end
               CTL_CMD_START: begin
                  console_ff <= 1'b0;
                  halt_ff    <= 1'b0;
                  start_ff   <= '{valid: 1'b1, addr: {pwdata[31:2], 2'b00}};
               end
               default: ;
            endcase
         end
      end
   end

   // Forwarding to the operating system
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         os_ff <= '0;
      end else begin
         os_ff.valid <= rx_char.valid && !console_ff
                        && !(ctl_p_in && key_enable);
         os_ff.data  <= ch;
      end
   end

   // Output flow state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discard_ff <= 1'b0;
         suspend_ff <= 1'b0;
      end else begin
         if (rx_con && !esc_ff && ch == CTL_CH_CTRL_O) begin
            discard_ff <= !discard_ff;
         end
         if (abort_in || !console_ff || seq_ff == CTL_S_PROMPT1
             || (apb_wr && paddr == CTL_A_ERR)) begin
            discard_ff <= 1'b0;
         end
         if (rx_con && !esc_ff && ch == CTL_CH_CTRL_S) begin
            suspend_ff <= 1'b1;
         end
         if (rx_char.valid && console_ff && ch == CTL_CH_CTRL_Q) begin
            suspend_ff <= 1'b0;
         end
      end
   end

   // Baud stepping on break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_ff <= CTL_BAUD_RST;
      end else if (apb_wr && paddr == CTL_A_CTRL) begin
         baud_ff <= pwdata[4:2];
      end else if (rx_break && ctrl_ff[0]) begin
         baud_ff <= (baud_ff == CTL_BAUD_MAX) ? 3'h0 : baud_ff + 3'h1;
      end
   end

   // Line editing, echo generation and error printing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_ff      <= '0;
         esc_ff      <= 1'b0;
         hdel_ff     <= 1'b0;
         line_rdy_ff <= 1'b0;
         seq_ff      <= CTL_S_IDLE;
         seq_reprint_ff <= 1'b0;
         rp_ix_ff    <= '0;
         err_busy_ff <= 1'b0;
         err_pos_ff  <= '0;
         err_code_ff <= '0;
         err_node_ff <= '0;
         letter_ff   <= '0;
         q_push      <= '0;
      end else begin
         q_push <= '0;
         if (apb_rd && paddr == CTL_A_LINE && line_rdy_ff
             && rd_ix_ff == len_ff) begin
            line_rdy_ff <= 1'b0;
            len_ff      <= '0;
         end
         if (seq_ff != CTL_S_IDLE && q_room) begin
            q_push.valid <= !discard_ff;
            unique case (seq_ff)
               CTL_S_CRLF_CR: begin
                  q_push.data <= CTL_CH_CR;
                  seq_ff <= CTL_S_CRLF_LF;
               end
               CTL_S_CRLF_LF: begin
                  q_push.data <= CTL_CH_LF;
                  rp_ix_ff <= '0;
                  seq_ff <= seq_reprint_ff ? CTL_S_REPRINT : CTL_S_PROMPT1;
               end
               CTL_S_PROMPT1: begin
                  q_push <= '{valid: 1'b1, data: CTL_CH_GT};
                  seq_ff <= CTL_S_PROMPT2;
               end
               CTL_S_PROMPT2: begin
                  q_push.data <= CTL_CH_GT;
                  seq_ff <= CTL_S_PROMPT3;
               end
               CTL_S_PROMPT3: begin
                  q_push.data <= CTL_CH_GT;
                  seq_ff <= CTL_S_PROMPT4;
               end
               CTL_S_PROMPT4: begin
                  q_push.data <= CTL_CH_SPACE;
                  seq_ff <= CTL_S_IDLE;
               end
               CTL_S_REPRINT: begin
                  if (rp_ix_ff == len_ff) begin
                     q_push.valid <= 1'b0;
                     seq_ff <= CTL_S_IDLE;
                  end else begin
                     q_push.data <= line_ff[rp_ix_ff];
                     rp_ix_ff <= rp_ix_ff + 7'h1;
                  end
               end
               CTL_S_ERASE2: begin
                  q_push.data <= CTL_CH_SPACE;
                  seq_ff <= CTL_S_ERASE3;
               end
               CTL_S_ERASE3: begin
                  q_push.data <= CTL_CH_BS;
                  seq_ff <= CTL_S_IDLE;
               end
               CTL_S_LETTER: begin
                  q_push <= '{valid: 1'b1, data: letter_ff};
                  seq_ff <= (letter_ff == 8'h4F) ? CTL_S_CR_ONLY : CTL_S_CRLF_CR;
               end
               CTL_S_CR_ONLY: begin
                  q_push <= '{valid: 1'b1, data: CTL_CH_CR};
                  seq_ff <= CTL_S_IDLE;
               end
               default: seq_ff <= CTL_S_IDLE;
            endcase
         end else if (err_busy_ff && q_room) begin
            q_push.valid <= 1'b1;
            err_pos_ff <= err_pos_ff + 4'h1;
            unique case (err_pos_ff)
               4'h0: q_push.data <= CTL_CH_N;
               4'h1: q_push.data <= CTL_CH_SPACE;
               4'h2: q_push.data <= hex(err_node_ff);
               4'h3: q_push.data <= CTL_CH_COLON;
               4'h4: q_push.data <= CTL_CH_SPACE;
               4'h5: q_push.data <= CTL_CH_QMARK;
               4'h6: q_push.data <= hex(err_code_ff[15:12]);
               4'h7: q_push.data <= hex(err_code_ff[11:8]);
               4'h8: q_push.data <= hex(err_code_ff[7:4]);
               4'h9: q_push.data <= hex(err_code_ff[3:0]);
               default: begin
                  q_push.data <= CTL_CH_SPACE;
                  err_busy_ff <= 1'b0;
               end
            endcase
         end else if (apb_wr && paddr == CTL_A_ERR && !line_busy) begin
            err_code_ff <= pwdata[15:0];
            err_node_ff <= pwdata[19:16];
            err_pos_ff  <= pwdata[20] ? 4'h0 : 4'h5;
            err_busy_ff <= 1'b1;
         end else if (apb_wr && paddr == CTL_A_TXD && !line_busy) begin
            q_push <= '{valid: !discard_ff, data: pwdata[7:0]};
         end else if (rx_break && ctrl_ff[0] && console_ff) begin
            seq_reprint_ff <= 1'b0;
            seq_ff <= CTL_S_CRLF_CR;
         end else if (rx_con) begin
            esc_ff <= 1'b0;
            letter_ff <= ch + CTL_ASCII_CTRL_OFS;
            if (hdel_ff && !(ch == CTL_CH_DEL && !esc_ff)) begin
               hdel_ff <= 1'b0;
            end
            if (esc_ff) begin
               if (!line_rdy_ff && len_ff < 7'(CTL_LINE_MAX)) begin
                  line_ff[len_ff] <= ch;
                  len_ff <= len_ff + 7'h1;
               end
               q_push <= '{valid: !discard_ff, data: ch};
            end else begin
               unique case (ch)
                  CTL_CH_CTRL_C, CTL_CH_CTRL_P, CTL_CH_CTRL_U: begin
                     len_ff <= '0;
                     line_rdy_ff <= 1'b0;
                     q_push <= '{valid: 1'b1, data: CTL_CH_CARET};
                     seq_reprint_ff <= 1'b0;
                     seq_ff <= CTL_S_LETTER;
                  end
                  CTL_CH_CTRL_O: begin
                     q_push <= '{valid: !discard_ff, data: CTL_CH_CARET};
                     seq_ff <= discard_ff ? CTL_S_IDLE : CTL_S_LETTER;
                  end
                  CTL_CH_CTRL_R: begin
                     q_push <= '{valid: !discard_ff, data: CTL_CH_CARET};
                     seq_reprint_ff <= 1'b1;
                     seq_ff <= CTL_S_LETTER;
                  end
                  CTL_CH_CTRL_S, CTL_CH_CTRL_Q: ;
                  CTL_CH_ESC: begin
                     esc_ff <= 1'b1;
                     q_push <= '{valid: !discard_ff, data: CTL_CH_DOLLAR};
                  end
                  CTL_CH_CR: begin
                     line_rdy_ff <= 1'b1;
                     q_push <= '{valid: !discard_ff, data: CTL_CH_CR};
                  end
                  CTL_CH_DEL: begin
                     if (len_ff != '0 && !line_rdy_ff) begin
                        len_ff <= len_ff - 7'h1;
                        if (ctrl_ff[1]) begin
                           hdel_ff <= 1'b1;
                           q_push <= '{valid: !discard_ff,
                                       data: hdel_ff ? line_ff[len_ff-7'h1]
                                                     : CTL_CH_BSL};
                           if (!hdel_ff) begin
                              rp_ix_ff <= len_ff - 7'h1;
                              seq_reprint_ff <= 1'b0;
                           end
                        end else begin
                           q_push <= '{valid: !discard_ff, data: CTL_CH_BS};
                           seq_ff <= CTL_S_ERASE2;
                        end
                     end
                  end
                  default: begin
                     if (hdel_ff) begin
                        q_push <= '{valid: !discard_ff, data: CTL_CH_BSL};
                     end else begin
                        q_push <= '{valid: !discard_ff, data: ch};
                     end
                     if (!line_rdy_ff && len_ff < 7'(CTL_LINE_MAX)) begin
                        line_ff[len_ff] <= ch;
                        len_ff <= len_ff + 7'h1;
                     end
                  end
               endcase
            end
         end
      end
   end

   function automatic logic [7:0] hex(input logic [3:0] v);
      return (v < 4'hA) ? CTL_CH_ZERO + {4'h0, v} : CTL_CH_A_MIN10 + {4'h0, v};
   endfunction

   // Transmit register and APB slave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ff      <= '0;
         ctrl_ff    <= CTL_CTRL_RST;
         prdata_ff  <= '0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         rd_ix_ff   <= '0;
      end else begin
         if (tx_ff.valid) begin
            tx_ff.valid <= 1'b0;
         end else if (tx_ready && !suspend_ff && q_head.valid) begin
            tx_ff <= q_head;
         end
         pready_ff  <= apb_acc;
         pslverr_ff <= 1'b0;
         if (apb_wr && paddr == CTL_A_CTRL) begin
            ctrl_ff <= {30'h0, pwdata[1:0]};
         end
         if (!line_rdy_ff) rd_ix_ff <= '0;
         if (apb_acc) begin
            prdata_ff <= 32'h0;
            unique case (paddr)
               CTL_A_CTRL: prdata_ff <= {27'h0, baud_ff, ctrl_ff[1:0]};
               CTL_A_STAT: prdata_ff <= {17'h0, err_busy_ff,
                                         line_rdy_ff, len_ff, 1'b0,
                                         suspend_ff, discard_ff,
                                         halt_ff, console_ff, esc_ff};
               CTL_A_LINE: begin
                  if (!pwrite && line_rdy_ff && rd_ix_ff != len_ff) begin
                     prdata_ff <= {24'h0, line_ff[rd_ix_ff]};
                     rd_ix_ff  <= rd_ix_ff + 7'h1;
                  end
               end
               CTL_A_CMD, CTL_A_ERR, CTL_A_TXD: ;
               default: pslverr_ff <= 1'b1;
            endcase
         end
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign os_char        = os_ff;
   assign tx_char        = tx_ff;
   assign baud_sel       = baud_ff;
   assign boot_cpu_halt  = halt_ff;
   assign boot_cpu_start = start_ff;
   assign passthru_end   = pend_ff;
endmodule

// ==== rtl/ctl_pkg.sv ====
// Package for the console terminal line handler: codes, types, constants.
// Assumes a single pclk domain; shared by the handler and its echo queue.
package ctl_pkg;
   localparam int unsigned CTL_CLK_MHZ   = 125;
   localparam int unsigned CTL_LINE_MAX  = 80;
   localparam int unsigned CTL_IDX_W     = 7;
   localparam int unsigned CTL_ECHO_DEPTH = 16;
   localparam int unsigned CTL_ECHO_AW   = 4;

   localparam logic [7:0] CTL_ASCII_CTRL_OFS = 8'h40;
   localparam logic [7:0] CTL_CH_CTRL_C = 8'h43 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_O = 8'h4F - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_P = 8'h50 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_Q = 8'h51 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_R = 8'h52 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_S = 8'h53 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_CTRL_U = 8'h55 - CTL_ASCII_CTRL_OFS;
   localparam logic [7:0] CTL_CH_DEL    = 8'h7F;
   localparam logic [7:0] CTL_CH_ESC    = 8'h1B;
   localparam logic [7:0] CTL_CH_CR     = 8'h0D;
   localparam logic [7:0] CTL_CH_LF     = 8'h0A;
   localparam logic [7:0] CTL_CH_CARET  = 8'h5E;
   localparam logic [7:0] CTL_CH_BSL    = 8'h5C;
   localparam logic [7:0] CTL_CH_DOLLAR = 8'h24;
   localparam logic [7:0] CTL_CH_BS     = 8'h08;
   localparam logic [7:0] CTL_CH_SPACE  = 8'h20;
   localparam logic [7:0] CTL_CH_GT     = 8'h3E;
   localparam logic [7:0] CTL_CH_QMARK  = 8'h3F;
   localparam logic [7:0] CTL_CH_COLON  = 8'h3A;
   localparam logic [7:0] CTL_CH_N      = 8'h4E;
   localparam logic [7:0] CTL_CH_ZERO   = 8'h30;
   localparam logic [7:0] CTL_CH_A_MIN10 = 8'h37;

   // Baud index 0..7 = 300,600,1200,2400,4800,9600,19200,38400
   localparam logic [2:0] CTL_BAUD_RST  = 3'h2;
   localparam logic [2:0] CTL_BAUD_MAX  = 3'h7;

   // APB map
   localparam logic [7:0] CTL_A_CTRL    = 8'h00;
   localparam logic [7:0] CTL_A_STAT    = 8'h04;
   localparam logic [7:0] CTL_A_CMD     = 8'h08;
   localparam logic [7:0] CTL_A_ERR     = 8'h0C;
   localparam logic [7:0] CTL_A_LINE    = 8'h10;
   localparam logic [7:0] CTL_A_TXD     = 8'h14;
   localparam logic [31:0] CTL_CTRL_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      CTL_CMD_NONE, CTL_CMD_CONTINUE, CTL_CMD_START
   } ctl_cmd_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ctl_char_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } ctl_start_t;
endpackage

// ==== rtl/ctl_echo_q.sv ====
// Echo/output queue for the console terminal line handler.
// Assumes the consumer stalls it by holding pop_en low while suspended.
`timescale 1ns/10ps
module ctl_echo_q
   import ctl_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire ctl_char_t      push,
   output logic                can_push,
   input  wire logic           pop_en,
   output ctl_char_t           head
);
   logic [7:0]             mem_ff [CTL_ECHO_DEPTH];
   logic [CTL_ECHO_AW-1:0] wr_ff;
   logic [CTL_ECHO_AW-1:0] rd_ff;
   logic [CTL_ECHO_AW:0]   cnt_ff;
   logic                   do_pop;
   logic                   do_push;

   assign can_push = (cnt_ff < 5'(CTL_ECHO_DEPTH - 4));
   assign do_pop   = pop_en && (cnt_ff != '0);
   assign do_push  = push.valid && (cnt_ff != 5'(CTL_ECHO_DEPTH));
   assign head     = '{valid: (cnt_ff != '0), data: mem_ff[rd_ff]};

   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem_ff[wr_ff] <= push.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ff <= wr_ff + 4'h1;
         end
         if (do_pop) begin
            rd_ff <= rd_ff + 4'h1;
         end
         cnt_ff <= cnt_ff + 5'(do_push) - 5'(do_pop);
      end
   end
endmodule

// ==== testbench/ctl_line_handler_props.sv ====
// Checker on the line handler ports: forwarding, mode entry, baud steps.
// Assumes it is bound onto ctl_line_handler and sees only its ports.
`timescale 1ns/10ps
module ctl_chk
   import ctl_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire ctl_char_t  rx_char,
   input wire logic       rx_break,
   input wire logic       key_enable,
   input wire ctl_char_t  os_char,
   input wire ctl_char_t  tx_char,
   input wire logic [2:0] baud_sel,
   input wire logic       boot_cpu_halt,
   input wire ctl_start_t boot_cpu_start,
   input wire logic       passthru_end
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cp;
   assign cp = rx_char.valid && rx_char.data == CTL_CH_CTRL_P && !boot_cpu_halt;
   chk_baud_reset: assert property (
      $rose(presetn) |-> baud_sel == CTL_BAUD_RST)
      else $error("baud not 1200 after reset");
   chk_os_forward: assert property (
      rx_char.valid && !boot_cpu_halt && (!cp || !key_enable)
      |=> os_char.valid && os_char.data == $past(rx_char.data))
      else $error("program mode byte not forwarded");
   chk_console_hold: assert property (
      rx_char.valid && boot_cpu_halt |=> !os_char.valid)
      else $error("console byte reached the system");
   chk_secure_ctrlp: assert property (
      cp && !key_enable |=> (!boot_cpu_halt && !tx_char.valid) [*4])
      else $error("secured ctrl-P changed mode or echoed");
   chk_enter_console: assert property (
      cp && key_enable |-> ##[1:2] boot_cpu_halt)
      else $error("ctrl-P did not enter console");
   chk_passthru_end: assert property (
      cp && key_enable |-> ##[1:2] passthru_end)
      else $error("ctrl-P did not end pass-through");
   chk_baud_step: assert property (
      $changed(baud_sel) && !$past(psel) && !$past(psel, 2)
      |-> baud_sel == $past(baud_sel) + 3'h1)
      else $error("baud step not to next rate");
   chk_start_leave: assert property (
      boot_cpu_start.valid |-> ##[0:2] !boot_cpu_halt)
      else $error("start left console halt set");
   cover property (cp && key_enable);
   cover property (rx_break);
   cover property (boot_cpu_start.valid);
endmodule
bind ctl_line_handler ctl_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .rx_char(rx_char), .rx_break(rx_break),
   .key_enable(key_enable), .os_char(os_char), .tx_char(tx_char),
   .baud_sel(baud_sel), .boot_cpu_halt(boot_cpu_halt),
   .boot_cpu_start(boot_cpu_start), .passthru_end(passthru_end));

// ==== testbench/ctl_term.sv ====
// Console terminal model: collects echo bytes, stalls at random.
// Assumes tx_char carries one byte per valid cycle.
`timescale 1ns/10ps
module ctl_term
   import ctl_pkg::*;
(
   input  wire logic      pclk,
   input  wire ctl_char_t tx_char,
   output logic           tx_ready
);
   logic [7:0] seen[$];
   initial tx_ready = 1'b1;
   always @(posedge pclk) begin
      if (tx_char.valid === 1'b1)
         seen.push_back(tx_char.data);
      tx_ready <= ($urandom % 4) != 0;
   end
endmodule

// ==== testbench/tb_ctl_line_handler.sv ====
// Bench for ctl_line_handler: APB tasks, typed bytes, queue model.
// Assumes ctl_term on the terminal side and the bound checker.
`timescale 1ns/10ps
module tb_ctl_line_handler
   import ctl_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        rx_break, key_enable, key_halt, tx_ready;
   logic        boot_cpu_halt, passthru_end, pte;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, sa, st_addr;
   logic [2:0]  baud_sel;
   ctl_char_t   rx_char, os_char, tx_char;
   ctl_start_t  boot_cpu_start;
   logic [7:0]  os_q[$], exp_q[$];
   int          bad_count, n_compared, cyc, baud, cons, n;
   ctl_line_handler DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_char, .rx_break, .key_enable,
      .key_halt, .os_char, .tx_char, .tx_ready, .baud_sel, .boot_cpu_halt,
      .boot_cpu_start, .passthru_end);
   ctl_term term (.pclk, .tx_char, .tx_ready);
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (os_char.valid === 1'b1)
         os_q.push_back(os_char.data);
      if (passthru_end === 1'b1)
         pte <= 1'b1;
      if (boot_cpu_start.valid === 1'b1)
         st_addr <= boot_cpu_start.addr;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task send(input logic [7:0] b, input int gap);
      @(posedge pclk);
      rx_char <= '{1'b1, b};
      @(posedge pclk);
      rx_char <= '{1'b0, 8'h00};
      repeat (gap) @(posedge pclk);
      if (cons == 0 && !(b == CTL_CH_CTRL_P && key_enable))
         exp_q.push_back(b);
   endtask
   task typ(input string s);
      for (int i = 0; i < s.len(); i++)
         send(s[i], 80);
   endtask
   task stat_is(input int b, input logic v);
      apb(1'b0, CTL_A_STAT, 32'h0);
      chk("stat", rd[b], v);
   endtask
   task line_is(input string s);
      stat_is(13, 1'b1);
      for (int i = 0; i < s.len(); i++) begin
         apb(1'b0, CTL_A_LINE, 32'h0);
         chk("line", rd[7:0], s[i]);
      end
      apb(1'b0, CTL_A_LINE, 32'h0);
   endtask
   task err_is(input logic [31:0] w, input string s);
      n = term.seen.size();
      apb(1'b1, CTL_A_ERR, w);
      repeat (300) @(posedge pclk);
      for (int i = 0; i < s.len(); i++)
         chk("err", term.seen[n + i], s[i]);
   endtask
   initial begin
      {psel, penable, pwrite, rx_break, key_halt, key_enable, pte} = 0;
      {paddr, pwdata, rx_char, bad_count, n_compared, cyc, cons} = 0;
      baud = 2;
      void'($urandom(84));
      presetn = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("baud", baud_sel, CTL_BAUD_RST);
      repeat (6) send(8'($urandom % 96) + 8'h20, 3);
      send(CTL_CH_CTRL_P, 3);
      chk("halt", boot_cpu_halt, 1'b0);
      apb(1'b1, CTL_A_CTRL, 32'h9);
      for (int i = 0; i < 9; i++) begin
         @(posedge pclk);
         rx_break <= 1'b1;
         @(posedge pclk);
         rx_break <= 1'b0;
         repeat (3) @(posedge pclk);
         baud = (baud + 1) % 8;
         chk("baud", baud_sel, baud);
      end
      key_enable <= 1'b1;
      send(CTL_CH_CTRL_P, 80);
      cons = 1;
      chk("halt", boot_cpu_halt, 1'b1);
      chk("pass_end", pte, 1'b1);
      typ("AB\r");
      line_is("AB");
      typ("XY\177\r");
      line_is("X");
      typ("Q\025Z\r");
      line_is("Z");
      typ("K\003M\r");
      line_is("M");
      typ("W\020V\r");
      line_is("V");
      send(CTL_CH_ESC, 80);
      chk("dollar", term.seen[$], CTL_CH_DOLLAR);
      typ("\025\r");
      line_is("\025");
      send(CTL_CH_CTRL_O, 80);
      chk("o_echo", term.seen[$ - 1], 8'h4F);
      chk("o_cr", term.seen[$], CTL_CH_CR);
      stat_is(3, 1'b1);
      send(CTL_CH_CTRL_C, 80);
      stat_is(3, 1'b0);
      send(CTL_CH_CTRL_S, 80);
      stat_is(4, 1'b1);
      n = term.seen.size();
      send(8'h41, 80);
      chk("held", term.seen.size(), n);
      send(CTL_CH_CTRL_Q, 80);
      stat_is(4, 1'b0);
      chk("resumed", term.seen[$], 8'h41);
      typ("\r");
      line_is("A");
      err_is(32'h0000_AB12, "?AB12");
      err_is(32'h0015_0006, "N 5: ?0006");
      sa = $urandom & 32'hFFFF_FFFC;
      apb(1'b1, CTL_A_CMD, sa | 32'h2);
      repeat (4) @(posedge pclk);
      chk("start", st_addr, sa);
      chk("halt", boot_cpu_halt, 1'b0);
      chk("os_n", os_q.size(), exp_q.size());
      foreach (exp_q[i]) chk("os", os_q[i], exp_q[i]);
      key_halt <= 1'b1;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("halt", boot_cpu_halt, 1'b1);
      end_sim();
   end
endmodule
